// file: design/fifo_ctrl_pkg.sv
// Package with constants and carrier types for the central FIFO controller.
package fifo_ctrl_pkg;
  localparam int DATA_W = 8;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  // Fixed vector code of this controller at the interrupt controller.
  localparam logic [6:0] VECTOR_CODE = 7'h28;
  // Status bit positions within a slice's event status and mask.
  localparam int EV_MEM = 0;
  localparam int EV_READY = 1;
  localparam int EV_OVR = 2;
  localparam int EV_UNR = 3;
  localparam int EV_ALARM = 4;
  localparam int EV_FULL = 5;
  localparam int EV_EMPTY = 6;
  localparam int EV_W = 7;
  localparam logic [EV_W-1:0] STATUS_RESET = 7'h00;
  localparam logic [EV_W-1:0] MASK_RESET = 7'h00;
  localparam logic [CNT_W-1:0] ALARM_RESET = 5'h01;

  // One slice's data port from the processor or DMA side.
  typedef struct packed {
    logic wr;
    logic rd;
    logic bad_access;
    logic [DATA_W-1:0] wdata;
  } slice_req_s;

  // Software control for one slice.
  typedef struct packed {
    logic [EV_W-1:0] clear;
    logic [EV_W-1:0] mask;
    logic [CNT_W-1:0] alarm_level;
    logic dma_en;
  } slice_ctl_s;

  // Observable state of one slice.
  typedef struct packed {
    logic [EV_W-1:0] status;
    logic [CNT_W-1:0] count;
    logic irq;
  } slice_stat_s;
endpackage

// file: design/central_fifo_controller.sv
// Central FIFO controller with transmit and receive slices and event status.
// Overview of operation
// - A pending status bit clears only when software writes one to it.
// - Interrupt stays asserted while any enabled status bit remains set.
// - Improper data register access sets the memory access error bit.
// - Data ready is set whenever the slice holds at least one word.
// - Writing a full transmit slice sets the overrun error bit; the receive slice never sets it.
// - Reading an empty slice sets the underrun error bit.
// - Alarm is set when the word count reaches the programmed alarm level.
// - Full is set when the slice has no free entry.
// - Empty is set when the slice contains no words.
// - The interrupt is identified by the fixed 7-bit vector code.
// - A summary gives one pending bit each for transmit and receive.
// - DMA transmit requests until alarm level, then waits for empty.
// - DMA receive requests from alarm level until the slice is empty.
// - Each event reaches the interrupt only when its mask bit is enabled.
// - Shift side never writes a full receive slice.
`timescale 1ns/1ps
module central_fifo_controller
  import fifo_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input fifo_ctrl_pkg::slice_req_s tx_host,
  input wire logic tx_shift_rd,
  output logic [fifo_ctrl_pkg::DATA_W-1:0] tx_shift_data,
  output logic tx_shift_valid,
  input fifo_ctrl_pkg::slice_req_s rx_host,
  output logic [fifo_ctrl_pkg::DATA_W-1:0] rx_rdata,
  input wire logic rx_shift_wr,
  input wire logic [fifo_ctrl_pkg::DATA_W-1:0] rx_shift_data,
  output logic rx_shift_ready,
  input fifo_ctrl_pkg::slice_ctl_s tx_ctl,
  input fifo_ctrl_pkg::slice_ctl_s rx_ctl,
  input wire logic eof_cmd,
  output logic tx_eof_pending,
  output fifo_ctrl_pkg::slice_stat_s tx_stat,
  output fifo_ctrl_pkg::slice_stat_s rx_stat,
  output logic tx_dma_req,
  output logic rx_dma_req,
  output logic [1:0] pending_summary,
  output logic irq,
  output logic [6:0] irq_vector
);
  import fifo_ctrl_pkg::*;

  logic [DATA_W-1:0] tx_mem [DEPTH];
  logic [DATA_W-1:0] rx_mem [DEPTH];
  logic [PTR_W-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [CNT_W-1:0] tx_cnt, rx_cnt;
  logic [EV_W-1:0] tx_sts, rx_sts;
  logic tx_full, tx_empty, rx_full, rx_empty;
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic tx_loop_fill, rx_loop_drain;
  logic [EV_W-1:0] tx_set, rx_set;

  // Level conditions of a slice, shared by both slices.
  function automatic logic [EV_W-1:0] level_events(input logic [CNT_W-1:0] cnt,
                                                   input logic [CNT_W-1:0] alarm);
    logic [EV_W-1:0] ev;
    ev = '0;
    ev[EV_READY] = (cnt != '0);
    ev[EV_ALARM] = (cnt >= alarm);
    ev[EV_FULL] = (cnt == CNT_W'(DEPTH));
    ev[EV_EMPTY] = (cnt == '0);
    return ev;
  endfunction

  // Sticky update: the set term wins over a simultaneous clear.
  function automatic logic [EV_W-1:0] sticky(input logic [EV_W-1:0] cur,
                                             input logic [EV_W-1:0] set,
                                             input logic [EV_W-1:0] clr);
    return (cur & ~clr) | set;
  endfunction

  assign tx_full = (tx_cnt == CNT_W'(DEPTH));
  assign tx_empty = (tx_cnt == '0);
  assign rx_full = (rx_cnt == CNT_W'(DEPTH));
  assign rx_empty = (rx_cnt == '0);
  assign tx_push = tx_host.wr && !tx_full;
  assign tx_pop = tx_shift_rd && !tx_empty;
  assign rx_pop = rx_host.rd && !rx_empty;
  // The shift side is held off a full receive slice rather than flagged.
  assign rx_shift_ready = !rx_full;
  assign rx_push = rx_shift_wr && !rx_full;
  assign tx_shift_valid = !tx_empty;

  // Transmit storage and pointers.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
      tx_shift_data <= '0;
    end
    else
    begin
      if (tx_push)
      begin
        tx_mem[tx_wp] <= tx_host.wdata;
        tx_wp <= tx_wp + 1'b1;
      end
      if (tx_pop)
      begin
        tx_rp <= tx_rp + 1'b1;
      end
      tx_shift_data <= tx_mem[tx_pop ? tx_rp + 1'b1 : tx_rp];
      tx_cnt <= tx_cnt + CNT_W'(tx_push) - CNT_W'(tx_pop);
    end
  end

  // Receive storage and pointers; read data is registered on each pop.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
      rx_rdata <= '0;
    end
    else
    begin
      if (rx_push)
      begin
        rx_mem[rx_wp] <= rx_shift_data;
        rx_wp <= rx_wp + 1'b1;
      end
      if (rx_pop)
      begin
        rx_rdata <= rx_mem[rx_rp];
        rx_rp <= rx_rp + 1'b1;
      end
      rx_cnt <= rx_cnt + CNT_W'(rx_push) - CNT_W'(rx_pop);
    end
  end

  // End-of-frame marker: armed by the command, consumed by the next write.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_eof_pending <= 1'b0;
    else if (eof_cmd)
      tx_eof_pending <= 1'b1;
    else if (tx_push)
      tx_eof_pending <= 1'b0;
  end

  // Event terms of this cycle, kept apart so the clocked status update stays non-blocking.
  always_comb
  begin
    tx_set = level_events(tx_cnt, tx_ctl.alarm_level);
    tx_set[EV_MEM] = tx_host.bad_access || tx_host.rd;
    tx_set[EV_OVR] = tx_host.wr && tx_full;
    tx_set[EV_UNR] = tx_shift_rd && tx_empty;
    rx_set = level_events(rx_cnt, rx_ctl.alarm_level);
    rx_set[EV_MEM] = rx_host.bad_access || rx_host.wr;
    rx_set[EV_OVR] = 1'b0;
    rx_set[EV_UNR] = rx_host.rd && rx_empty;
  end

  // Sticky status; level events are latched, so they persist once seen.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_sts <= STATUS_RESET;
      rx_sts <= STATUS_RESET;
    end
    else
    begin
      tx_sts <= sticky(tx_sts, tx_set, tx_ctl.clear);
      rx_sts <= sticky(rx_sts, rx_set, rx_ctl.clear);
    end
  end

  // DMA loop state: transmit fills to alarm, receive drains to empty.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_loop_fill <= 1'b1;
      rx_loop_drain <= 1'b0;
    end
    else
    begin
      if (!tx_ctl.dma_en || tx_empty)
        tx_loop_fill <= 1'b1;
      else if (tx_cnt >= tx_ctl.alarm_level)
        tx_loop_fill <= 1'b0;
      if (!rx_ctl.dma_en || rx_empty)
        rx_loop_drain <= 1'b0;
      else if (rx_cnt >= rx_ctl.alarm_level)
        rx_loop_drain <= 1'b1;
    end
  end

  // The stored alarm compare can lag one write, so the live count also gates.
  assign tx_dma_req = tx_ctl.dma_en && tx_loop_fill && (tx_cnt < tx_ctl.alarm_level)
                      && !tx_full;
  assign rx_dma_req = rx_ctl.dma_en && !rx_empty &&
                      (rx_loop_drain || rx_cnt >= rx_ctl.alarm_level);

  // Interrupt is a level of enabled sticky bits, so an uncleared event re-fires.
  assign pending_summary[0] = |(tx_sts & tx_ctl.mask);
  assign pending_summary[1] = |(rx_sts & rx_ctl.mask);
  assign irq = |pending_summary;
  assign irq_vector = VECTOR_CODE;

  assign tx_stat = '{status: tx_sts, count: tx_cnt, irq: pending_summary[0]};
  assign rx_stat = '{status: rx_sts, count: rx_cnt, irq: pending_summary[1]};

  a_clear_needs_write: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(tx_sts[EV_OVR]) |-> $past(tx_ctl.clear[EV_OVR]))
    else $error("overrun bit fell without a clear");
  a_irq_level_held: assert property (@(posedge clk) disable iff (!reset_n)
    (|(rx_sts & rx_ctl.mask)) |-> irq)
    else $error("irq low while enabled bit set");
  a_mem_error_set: assert property (@(posedge clk) disable iff (!reset_n)
    rx_host.wr |=> rx_sts[EV_MEM])
    else $error("memory error not flagged");
  a_ready_tracks: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_cnt != '0) |=> tx_sts[EV_READY])
    else $error("ready not flagged");
  a_overrun_set: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_host.wr && tx_full) |=> tx_sts[EV_OVR] && (tx_cnt <= $past(tx_cnt)))
    else $error("overrun not flagged or write taken");
  a_underrun_set: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_host.rd && rx_empty) |=> rx_sts[EV_UNR])
    else $error("underrun not flagged");
  a_alarm_set: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_cnt >= rx_ctl.alarm_level) |=> rx_sts[EV_ALARM])
    else $error("alarm not flagged");
  a_full_set: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_cnt == CNT_W'(DEPTH)) |=> tx_sts[EV_FULL])
    else $error("full not flagged");
  a_empty_set: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_cnt == '0) |=> rx_sts[EV_EMPTY])
    else $error("empty not flagged");
  a_vector_fixed: assert property (@(posedge clk) disable iff (!reset_n)
    irq_vector == 7'h28)
    else $error("vector code wrong");
  a_mask_gates: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_ctl.mask == '0 && rx_ctl.mask == '0) |-> !irq)
    else $error("masked event reached irq");
  a_tx_dma_stop: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_cnt >= tx_ctl.alarm_level) |-> !tx_dma_req)
    else $error("tx dma request at alarm");
  a_rx_dma_drain: assert property (@(posedge clk) disable iff (!reset_n)
    rx_empty |-> !rx_dma_req)
    else $error("rx dma request on empty");
  a_rx_no_overfill: assert property (@(posedge clk) disable iff (!reset_n)
    rx_cnt <= CNT_W'(DEPTH))
    else $error("rx count above depth");
  a_sticky_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_sts[EV_UNR] && !tx_ctl.clear[EV_UNR]) |=> tx_sts[EV_UNR])
    else $error("sticky bit dropped");
endmodule

// file: test/shift_partner.sv
// Behavioural shift side that drains the transmit slice and feeds the receive slice.
`timescale 1ns/1ps
module shift_partner (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tx_go,
  input wire logic rx_go,
  input wire logic tx_shift_valid,
  input wire logic rx_shift_ready,
  output logic tx_shift_rd,
  output logic rx_shift_wr,
  output logic [7:0] rx_shift_data
);
  logic [7:0] seq;
  // Pops follow the valid level directly, so a registered lag can never pop an empty slice.
  assign tx_shift_rd = tx_go && tx_shift_valid;
  // Pushes are offered regardless of room, so a full slice must drop them itself.
  assign rx_shift_wr = rx_go;
  // The word sequence advances on each accepted push.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      seq <= 8'h10;
    else if (rx_shift_wr && rx_shift_ready)
      seq <= seq + 8'h01;
  end
  // An idle data line shows the inverse, so a stale word can never pass as fresh.
  assign rx_shift_data = rx_shift_wr ? seq : ~seq;
endmodule

// file: test/spi_fifo_event_controller_test.sv
// Self-checking bench for the central FIFO controller and its shift partner.
`timescale 1ns/1ps
module spi_fifo_event_controller_test;
  import fifo_ctrl_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic eof_cmd = 1'b0;
  logic tx_go = 1'b0;
  logic rx_go = 1'b0;
  slice_req_s tx_host = '0;
  slice_req_s rx_host = '0;
  slice_ctl_s tx_ctl = '0;
  slice_ctl_s rx_ctl = '0;
  slice_stat_s tx_stat, rx_stat;
  logic [7:0] tx_shift_data, rx_rdata, rx_shift_data;
  logic tx_shift_rd, tx_shift_valid, rx_shift_wr, rx_shift_ready, tx_eof_pending;
  logic tx_dma_req, rx_dma_req, irq;
  logic [1:0] pending_summary;
  logic [6:0] irq_vector;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  int k;

  central_fifo_controller dut_u (.clk, .reset_n, .tx_host, .tx_shift_rd, .tx_shift_data,
    .tx_shift_valid, .rx_host, .rx_rdata, .rx_shift_wr, .rx_shift_data, .rx_shift_ready,
    .tx_ctl, .rx_ctl, .eof_cmd, .tx_eof_pending, .tx_stat, .rx_stat, .tx_dma_req,
    .rx_dma_req, .pending_summary, .irq, .irq_vector);
  shift_partner partner_u (.clk, .reset_n, .tx_go, .rx_go, .tx_shift_valid,
    .rx_shift_ready, .tx_shift_rd, .rx_shift_wr, .rx_shift_data);

  // Free-running clock of 8 ns.
  always #4 clk = ~clk;

  // The whole run needs well under a thousand cycles, so this ceiling only cuts a hang.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Inputs always change 1 ns after the rising edge.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic push_tx(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++)
    begin
      tx_host.wr = 1'b1;
      tx_host.wdata = base + i[7:0];
      tick();
    end
    tx_host.wr = 1'b0;
  endtask

  task automatic clr_tx(input logic [6:0] bits);
    tx_ctl.clear = bits;
    tick();
    tx_ctl.clear = '0;
  endtask

  task automatic drain_tx();
    tx_go = 1'b1;
    for (k = 0; k < 40 && tx_stat.count !== 5'h00; k++)
      tick();
    tx_go = 1'b0;
    tick();
  endtask

  task automatic t_reset();
    tick();
    tick();
    check(irq_vector, VECTOR_CODE);
    check(tx_stat.status[EV_EMPTY], 1'b1);
    check(irq, 1'b0);
  endtask

  task automatic t_tx_fill();
    tx_ctl.alarm_level = 5'h04;
    clr_tx(7'h7f);
    push_tx(3, 8'ha0);
    tick();
    check(tx_stat.status[EV_ALARM], 1'b0);
    check(tx_stat.status[EV_READY], 1'b1);
    check(tx_shift_data, 8'ha0);
    push_tx(1, 8'ha3);
    tick();
    check(tx_stat.status[EV_ALARM], 1'b1);
    push_tx(12, 8'ha4);
    tick();
    check(tx_stat.count, 5'h10);
    check(tx_stat.status[EV_FULL], 1'b1);
    check(tx_stat.status[EV_OVR], 1'b0);
    push_tx(1, 8'hff);
    tick();
    check(tx_stat.status[EV_OVR], 1'b1);
    check(tx_stat.count, 5'h10);
    tx_host.rd = 1'b1;
    tick();
    tx_host.rd = 1'b0;
    tick();
    check(tx_stat.status[EV_MEM], 1'b1);
  endtask

  task automatic t_irq();
    tx_ctl.mask = 7'h04;
    tick();
    check(irq, 1'b1);
    check(pending_summary, 2'b01);
    clr_tx(7'h02);
    tick();
    check(irq, 1'b1);
    tx_ctl.mask = 7'h00;
    tick();
    check(irq, 1'b0);
    tx_ctl.mask = 7'h04;
    clr_tx(7'h04);
    tick();
    check(tx_stat.status[EV_OVR], 1'b0);
    check(irq, 1'b0);
    check(tx_stat.status[EV_FULL], 1'b1);
    tx_ctl.mask = 7'h00;
    drain_tx();
    check(tx_stat.status[EV_FULL], 1'b1);
    check(tx_stat.status[EV_EMPTY], 1'b1);
    // Interrupt-driven transmit: each empty event is answered with one alarm-sized packet.
    tx_ctl.mask = 7'h40;
    tick();
    check(irq, 1'b1);
    push_tx(4, 8'hc0);
    clr_tx(7'h40);
    check(tx_stat.status[EV_EMPTY], 1'b0);
    check(irq, 1'b0);
    drain_tx();
    check(irq, 1'b1);
    tx_ctl.mask = 7'h00;
    tick();
    check(irq, 1'b0);
  endtask

  task automatic t_dma_tx();
    clr_tx(7'h7f);
    tx_ctl.dma_en = 1'b1;
    tick();
    check(tx_dma_req, 1'b1);
    // The write is held across edges while the request stands, as a DMA engine would.
    tx_host.wr = 1'b1;
    tx_host.wdata = 8'h50;
    for (k = 0; k < 10 && tx_dma_req === 1'b1; k++)
      tick();
    tx_host.wr = 1'b0;
    check(tx_stat.count, 5'h04);
    tx_go = 1'b1;
    tick();
    tx_go = 1'b0;
    tick();
    check(tx_stat.count, 5'h03);
    check(tx_dma_req, 1'b0);
    drain_tx();
    check(tx_dma_req, 1'b1);
    tx_ctl.dma_en = 1'b0;
    eof_cmd = 1'b1;
    tick();
    eof_cmd = 1'b0;
    check(tx_eof_pending, 1'b1);
    push_tx(1, 8'h77);
    check(tx_eof_pending, 1'b0);
  endtask

  task automatic t_rx();
    rx_ctl.alarm_level = 5'h04;
    rx_ctl.clear = 7'h7f;
    tick();
    rx_ctl.clear = '0;
    check(rx_stat.status[EV_ALARM], 1'b0);
    rx_ctl.dma_en = 1'b1;
    rx_go = 1'b1;
    for (k = 0; k < 40 && rx_stat.count !== 5'h04; k++)
      tick();
    rx_go = 1'b0;
    tick();
    check(rx_stat.status[EV_ALARM], 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      check(rx_dma_req, 1'b1);
      rx_host.rd = 1'b1;
      tick();
      check(rx_rdata, 8'h10 + i[7:0]);
    end
    rx_host.rd = 1'b0;
    check(rx_dma_req, 1'b0);
    rx_ctl.clear = 7'h10;
    tick();
    rx_ctl.clear = '0;
    check(rx_stat.status[EV_ALARM], 1'b0);
    rx_host.rd = 1'b1;
    tick();
    rx_host.rd = 1'b0;
    rx_host.wr = 1'b1;
    tick();
    rx_host.wr = 1'b0;
    tick();
    check(rx_stat.status[EV_UNR], 1'b1);
    check(rx_stat.status[EV_MEM], 1'b1);
    rx_ctl.dma_en = 1'b0;
    rx_ctl.mask = 7'h20;
    rx_go = 1'b1;
    for (k = 0; k < 40 && rx_shift_ready !== 1'b0; k++)
      tick();
    tick();
    tick();
    rx_go = 1'b0;
    check(rx_stat.count, 5'h10);
    check(rx_stat.status[EV_OVR], 1'b0);
    check(pending_summary, 2'b10);
  endtask

  // Reset is held for four cycles, then each scenario runs in turn.
  initial
  begin
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    t_reset();
    t_tx_fill();
    t_irq();
    t_dma_tx();
    t_rx();
    stop_test();
  end
endmodule
